/* src/mbwlh_pkg.sv */
package mbwlh_pkg;

  // ---------------------------------------------------------------
  // Frame sizing and field values
  // ---------------------------------------------------------------
  localparam int FRAME_MAX = 80;
  localparam int HOLD_WORDS_DEF = 1024;
  localparam logic [15:0] MAX_WORDS = 16'h0020;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] FC_WR_ONE = 8'h06;
  localparam logic [7:0] FC_LOOP = 8'h08;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] ERR_FUNC = 8'h01;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_COUNT = 8'h03;
  localparam logic [7:0] FIXED_BODY = 8'h06;
  localparam logic [8:0] MULTI_HDR = 9'h007;
  localparam logic [2:0] RESP_LEN_OK = 3'h6;
  localparam logic [2:0] RESP_LEN_ERR = 3'h3;

  // ---------------------------------------------------------------
  // Check codes and ASCII framing characters
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] CHR_START = 8'h3a;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;

  typedef enum logic [2:0] {S_RX, S_EVAL, S_WRITE, S_SUM, S_TX} mbwlh_state_e;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] hex_char(logic [3:0] v);
    return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  // Bit 4 flags a legal hex digit
  function automatic logic [4:0] hex_val(logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
    begin
      r = {1'b1, c[3:0]};
    end
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
    begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    return r;
  endfunction

endpackage

/* src/mbwlh_handler.sv */
`timescale 1ns/1ns
// How it works
// - Code 06 stores value at word number
// - Single write carries one number, one word
// - Address 00 executes 06 and 10 writes
// - Single write reply echoes address, code, word
// - ASCII bytes as two hex characters
// - Loop-back carries zero sub-function, test word
// - Any loop-back test word accepted
// - Loop-back reply identical to request
// - Multi write fills consecutive words from start
// - Multi write limited to 32 words
// - Multi write function code is 10 hex
// - Start, count, byte count, then data
// - Data words applied in received order
// - Multi reply gives start and count only
// - RTU check is CRC-16
// - ASCII check is LRC byte
// - Invalid unicast request: no action, exception reply
// - Broadcast requests never get a reply
module mbwlh_handler #(
  parameter int HOLD_WORDS = mbwlh_pkg::HOLD_WORDS_DEF
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic ascii_mode, // High for ASCII framing
  input wire logic [7:0] station_addr, // Own station address
  input wire logic rx_valid, // Received byte/char valid
  input wire logic [7:0] rx_data, // Received byte/char
  input wire logic rx_eof, // RTU frame end pulse
  output logic rx_ready, // Ready for received data
  output logic tx_valid, // Reply byte/char valid
  output logic [7:0] tx_data, // Reply byte/char
  input wire logic tx_ready, // Reply sink ready
  output logic word_wr_valid, // Holding word write strobe
  output logic [15:0] word_wr_addr, // Holding word number
  output logic [15:0] word_wr_data // Holding word value
);

  typedef struct packed {
    mbwlh_pkg::mbwlh_state_e st;
    logic [mbwlh_pkg::FRAME_MAX-1:0][7:0] fb;
    logic [6:0] cnt;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic [3:0] nib;
    logic phase;
    logic started;
    logic bad;
    logic ovf;
    logic [7:0] err;
    logic [2:0] rlen;
    logic [2:0] sidx;
    logic [5:0] widx;
    logic [4:0] tpos;
    logic tx_valid;
    logic [7:0] tx_data;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
  } mbwlh_reg_s;

  mbwlh_reg_s q;
  mbwlh_reg_s n;

  // ---------------------------------------------------------------
  // Frame field views
  // ---------------------------------------------------------------
  logic [7:0] f_fc;
  logic [15:0] f_w1;
  logic [15:0] f_w2;
  logic [7:0] f_bc;
  logic f_bcast;
  logic f_write;

  assign f_fc = q.fb[1];
  assign f_w1 = {q.fb[2], q.fb[3]};
  assign f_w2 = {q.fb[4], q.fb[5]};
  assign f_bc = q.fb[6];
  assign f_bcast = (q.fb[0] == mbwlh_pkg::ADDR_BCAST);
  assign f_write = (f_fc == mbwlh_pkg::FC_WR_ONE) ||
                   (f_fc == mbwlh_pkg::FC_WR_MULTI);

  // Reply body: echo of the header or exception triple
  function automatic logic [7:0] resp_byte(logic [2:0] k);
    logic [7:0] r;
    r = q.fb[k];
    if (q.err != 8'h00)
    begin
      if (k == 3'h1)
      begin
        r = q.fb[1] | mbwlh_pkg::FC_EXC_FLAG;
      end
      else if (k == 3'h2)
      begin
        r = q.err;
      end
    end
    return r;
  endfunction

  // Character at reply position p, check bytes appended
  function automatic logic [7:0] tx_char(logic [4:0] p, logic [4:0] tot);
    logic [4:0] o;
    logic [7:0] b;
    logic [7:0] r;
    o = p - 5'h01;
    b = (o[4:1] < {1'b0, q.rlen}) ? resp_byte(o[3:1]) : q.lrc;
    if (ascii_mode)
    begin
      if (p == 5'h00)
      begin
        r = mbwlh_pkg::CHR_START;
      end
      else if (p == tot - 5'h02)
      begin
        r = mbwlh_pkg::CHR_CR;
      end
      else if (p == tot - 5'h01)
      begin
        r = mbwlh_pkg::CHR_LF;
      end
      else
      begin
        r = mbwlh_pkg::hex_char(o[0] ? b[3:0] : b[7:4]);
      end
    end
    else if (p < {2'b00, q.rlen})
    begin
      r = resp_byte(p[2:0]);
    end
    else
    begin
      r = (p == {2'b00, q.rlen}) ? q.crc[7:0] : q.crc[15:8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic rs;
    logic [7:0] rb;
    logic [4:0] hv;
    logic [7:0] ck;
    logic [7:0] nb;
    logic [7:0] e;
    logic wf;
    logic drop;
    logic chk_ok;
    logic [5:0] nw;
    logic [4:0] tot;
    int di;
    rs = 1'b0;
    rb = rx_data;
    hv = mbwlh_pkg::hex_val(rx_data);
    ck = ascii_mode ? 8'h01 : 8'h02;
    nb = {1'b0, q.cnt} - ck;
    e = 8'h00;
    wf = 1'b0;
    drop = 1'b0;
    chk_ok = ascii_mode ? (q.lrc == 8'h00) : (q.crc == 16'h0000);
    nw = (f_fc == mbwlh_pkg::FC_WR_ONE) ? 6'h01 : f_w2[5:0];
    tot = ascii_mode ? ({1'b0, q.rlen, 1'b0} + 5'h05)
                     : ({2'b00, q.rlen} + 5'h02);
    di = 7 + 2 * int'(q.widx);
    n = q;
    n.wr_valid = 1'b0;
    unique case (q.st)
      mbwlh_pkg::S_RX:
      begin
        if (!ascii_mode)
        begin
          rs = rx_valid;
          if (rx_eof && (q.cnt != 7'h00 || rx_valid))
          begin
            n.st = mbwlh_pkg::S_EVAL;
          end
        end
        else if (rx_valid && rx_data == mbwlh_pkg::CHR_START)
        begin
          n.started = 1'b1;
          n.cnt = 7'h00;
          n.ovf = 1'b0;
          n.bad = 1'b0;
          n.phase = 1'b0;
        end
        else if (rx_valid && q.started)
        begin
          if (rx_data == mbwlh_pkg::CHR_LF)
          begin
            n.st = mbwlh_pkg::S_EVAL;
          end
          else if (rx_data != mbwlh_pkg::CHR_CR)
          begin
            if (!hv[4])
            begin
              n.bad = 1'b1;
            end
            else if (!q.phase)
            begin
              n.nib = hv[3:0];
              n.phase = 1'b1;
            end
            else
            begin
              n.phase = 1'b0;
              rb = {q.nib, hv[3:0]};
              rs = 1'b1;
            end
          end
        end
        if (rs)
        begin
          if (q.cnt < 7'(mbwlh_pkg::FRAME_MAX))
          begin
            n.fb[q.cnt] = rb;
            n.cnt = q.cnt + 7'h01;
            n.crc = mbwlh_pkg::crc_step((q.cnt == 7'h00) ?
              mbwlh_pkg::CRC_INIT : q.crc, rb);
            n.lrc = ((q.cnt == 7'h00) ? 8'h00 : q.lrc) + rb;
          end
          else
          begin
            n.ovf = 1'b1;
          end
        end
      end
      mbwlh_pkg::S_EVAL:
      begin
        unique case (f_fc)
          mbwlh_pkg::FC_WR_ONE:
          begin
            wf = (nb == mbwlh_pkg::FIXED_BODY);
            if (f_w1 >= 16'(HOLD_WORDS))
            begin
              e = mbwlh_pkg::ERR_ADDR;
            end
          end
          mbwlh_pkg::FC_LOOP:
          begin
            wf = (nb == mbwlh_pkg::FIXED_BODY);
            if (f_w1 != 16'h0000)
            begin
              e = mbwlh_pkg::ERR_FUNC;
            end
          end
          mbwlh_pkg::FC_WR_MULTI:
          begin
            wf = ({1'b0, nb} >= mbwlh_pkg::MULTI_HDR);
            if (f_w2 == 16'h0000 || f_w2 > mbwlh_pkg::MAX_WORDS)
            begin
              e = mbwlh_pkg::ERR_COUNT;
            end
            else if ({8'h00, f_bc} != {f_w2[14:0], 1'b0} ||
                     {1'b0, nb} != mbwlh_pkg::MULTI_HDR + {1'b0, f_bc})
            begin
              e = mbwlh_pkg::ERR_COUNT;
            end
            else if ({1'b0, f_w1} + {1'b0, f_w2} > 17'(HOLD_WORDS))
            begin
              e = mbwlh_pkg::ERR_ADDR;
            end
          end
          default:
          begin
            wf = 1'b1;
            e = mbwlh_pkg::ERR_FUNC;
          end
        endcase
        drop = !chk_ok || q.ovf || q.bad || ({1'b0, q.cnt} < ck + 8'h02) ||
               !wf || (!f_bcast && q.fb[0] != station_addr) ||
               (f_bcast && (!f_write || e != 8'h00));
        n.err = e;
        n.rlen = (e != 8'h00) ? mbwlh_pkg::RESP_LEN_ERR
                              : mbwlh_pkg::RESP_LEN_OK;
        n.widx = 6'h00;
        n.sidx = 3'h0;
        n.tpos = 5'h00;
        n.cnt = 7'h00;
        n.started = 1'b0;
        n.bad = 1'b0;
        n.ovf = 1'b0;
        n.phase = 1'b0;
        n.crc = mbwlh_pkg::CRC_INIT;
        n.lrc = 8'h00;
        if (drop)
        begin
          n.st = mbwlh_pkg::S_RX;
        end
        else if (e == 8'h00 && f_write)
        begin
          n.st = mbwlh_pkg::S_WRITE;
        end
        else
        begin
          n.st = mbwlh_pkg::S_SUM;
        end
      end
      mbwlh_pkg::S_WRITE:
      begin
        n.wr_valid = 1'b1;
        n.wr_addr = f_w1 + {10'h000, q.widx};
        if (f_fc == mbwlh_pkg::FC_WR_ONE)
        begin
          n.wr_data = f_w2;
        end
        else
        begin
          n.wr_data = {q.fb[di], q.fb[di + 1]};
        end
        n.widx = q.widx + 6'h01;
        if (q.widx + 6'h01 == nw)
        begin
          n.st = f_bcast ? mbwlh_pkg::S_RX : mbwlh_pkg::S_SUM;
        end
      end
      mbwlh_pkg::S_SUM:
      begin
        rb = resp_byte(q.sidx);
        n.crc = mbwlh_pkg::crc_step(q.crc, rb);
        n.lrc = q.lrc + rb;
        n.sidx = q.sidx + 3'h1;
        if (q.sidx + 3'h1 == q.rlen)
        begin
          n.lrc = 8'h00 - (q.lrc + rb);
          n.st = mbwlh_pkg::S_TX;
        end
      end
      mbwlh_pkg::S_TX:
      begin
        if (!q.tx_valid || tx_ready)
        begin
          if (q.tpos == tot)
          begin
            n.tx_valid = 1'b0;
            n.st = mbwlh_pkg::S_RX;
          end
          else
          begin
            n.tx_valid = 1'b1;
            n.tx_data = tx_char(q.tpos, tot);
            n.tpos = q.tpos + 5'h01;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign rx_ready = (q.st == mbwlh_pkg::S_RX);
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign word_wr_valid = q.wr_valid;
  assign word_wr_addr = q.wr_addr;
  assign word_wr_data = q.wr_data;

endmodule

/* testbench/mbwlh_chk.sv */
`timescale 1ns/1ns
module mbwlh_chk (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic ascii_mode, // Framing
  input wire logic rx_valid, // Rx valid
  input wire logic rx_eof, // Rx end
  input wire logic rx_ready, // Rx ready
  input wire logic tx_valid, // Tx valid
  input wire logic [7:0] tx_data, // Tx data
  input wire logic tx_ready, // Tx ready
  input wire logic word_wr_valid, // Write strobe
  input wire logic [15:0] word_wr_addr // Write word
);
  // --------
  // Checks
  // --------
  logic [5:0] run_ff;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  always_ff @(posedge core_clk)
    run_ff <= (reset || !word_wr_valid) ? 6'h00 : run_ff + 6'h01;
  sequence s_last;
    tx_valid && tx_ready ##1 !tx_valid;
  endsequence
  sequence s_two_wr;
    word_wr_valid ##1 word_wr_valid;
  endsequence
  a_reset_idle: assert property ($fell(reset) |-> rx_ready && !tx_valid
    && !word_wr_valid) else $error("not idle after reset");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_data)) else $error("reply beat not held");
  a_tx_busy: assert property (tx_valid |-> !rx_ready)
    else $error("receive open while replying");
  a_wr_busy: assert property (word_wr_valid |-> !$past(rx_ready))
    else $error("write strobe not launched from busy state");
  a_addr_step: assert property (s_two_wr |-> word_wr_addr ==
    $past(word_wr_addr) + 16'h0001) else $error("word number skipped");
  a_burst_max: assert property (word_wr_valid |-> run_ff < 6'd32)
    else $error("more than 32 writes");
  a_eof_busy: assert property (!ascii_mode && rx_valid && rx_ready
    && rx_eof |=> !rx_ready) else $error("frame end not taken");
  a_rdy_back: assert property (s_last |-> ##[0:1] rx_ready)
    else $error("receive not reopened");
endmodule
bind mbwlh_handler mbwlh_chk mbwlh_chk_inst (.core_clk, .reset,
  .ascii_mode, .rx_valid, .rx_eof, .rx_ready, .tx_valid, .tx_data,
  .tx_ready, .word_wr_valid, .word_wr_addr);

/* testbench/mbwlh_host.sv */
`timescale 1ns/1ns
module mbwlh_host (
  input wire logic core_clk, // Clock
  input wire logic ascii_mode, // Framing
  input wire logic rx_ready, // Device ready
  output logic rx_valid, // Request valid
  output logic [7:0] rx_data, // Request byte
  output logic rx_eof, // Frame end
  input wire logic tx_valid, // Reply valid
  input wire logic [7:0] tx_data, // Reply byte
  output logic tx_ready // Reply accept
);
  // ------------
  // Host master
  // ------------
  typedef logic [7:0] mbwlh_q_t[$];
  logic slow = 0;
  initial
  begin
    rx_valid = 0;
    rx_data = 8'h00;
    rx_eof = 0;
    tx_ready = 1;
  end
  // Slow mode stalls every other cycle
  always @(posedge core_clk)
    #1 tx_ready = !slow || !tx_ready;
  function automatic logic [7:0] hx(logic [3:0] v);
    return v < 4'ha ? 8'h30 + v : 8'h37 + v;
  endfunction
  function automatic mbwlh_q_t enc(mbwlh_q_t b);
    mbwlh_q_t w;
    logic [15:0] c;
    logic [7:0] s;
    c = 16'hffff;
    s = 8'h00;
    foreach (b[i])
    begin
      s = s + b[i];
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    if (!ascii_mode)
      return {b, c[7:0], c[15:8]};
    s = -s;
    w = {8'h3a};
    foreach (b[i])
      w = {w, hx(b[i][7:4]), hx(b[i][3:0])};
    return {w, hx(s[7:4]), hx(s[3:0]), 8'h0d, 8'h0a};
  endfunction
  task automatic send(mbwlh_q_t b);
    mbwlh_q_t w;
    w = enc(b);
    foreach (w[i])
    begin
      rx_valid = 1;
      rx_data = w[i];
      rx_eof = !ascii_mode && i == w.size() - 1;
      do
        @(posedge core_clk);
      while (!rx_ready);
      #1;
    end
    rx_valid = 0;
    rx_data = ~rx_data;
    rx_eof = 0;
  endtask
  task automatic recv(int n, output mbwlh_q_t r);
    r = {};
    for (int t = 0; t < 400 && r.size() < n; t++)
    begin
      @(posedge core_clk);
      if (tx_valid && tx_ready)
        r.push_back(tx_data);
    end
    #1;
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  // ---------
  // Harness
  // ---------
  typedef logic [7:0] mbwlh_q_t[$];
  logic core_clk = 0, reset = 1, ascii_mode = 0;
  logic [7:0] station_addr = 8'h01, rx_data, tx_data;
  logic rx_valid, rx_eof, rx_ready, tx_valid, tx_ready, word_wr_valid;
  logic [15:0] word_wr_addr, word_wr_data;
  logic [31:0] wq[$];
  int errors = 0, n_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  mbwlh_handler #(.HOLD_WORDS(256)) mbwlh_handler_inst (.core_clk, .reset,
    .ascii_mode, .station_addr, .rx_valid, .rx_data, .rx_eof, .rx_ready,
    .tx_valid, .tx_data, .tx_ready, .word_wr_valid, .word_wr_addr,
    .word_wr_data);
  mbwlh_host host (.core_clk, .ascii_mode, .rx_ready, .rx_valid, .rx_data,
    .rx_eof, .tx_valid, .tx_data, .tx_ready);
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (word_wr_valid === 1'b1)
      wq.push_back({word_wr_addr, word_wr_data});
    if (cyc == 20000)
    begin
      errors += 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_checks += 1;
    if (s !== e)
    begin
      errors += 1;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic cq(mbwlh_q_t s, mbwlh_q_t e);
    chk(s.size(), e.size());
    foreach (e[i])
      if (i < s.size())
        chk(s[i], e[i]);
  endtask
  task automatic cw(mbwlh_q_t d, logic [15:0] a);
    chk(wq.size(), d.size() / 2);
    foreach (wq[i])
      chk(wq[i], {a + 16'(i), d[2 * i], d[2 * i + 1]});
  endtask
  task automatic xfer(mbwlh_q_t b, int n, output mbwlh_q_t r);
    wq = {};
    host.send(b);
    host.recv(n, r);
  endtask
  task automatic t_err(mbwlh_q_t b, logic [7:0] e);
    mbwlh_q_t r;
    xfer(b, 5, r);
    chk(wq.size(), 0);
    cq(r, host.enc({b[0], b[1] | 8'h80, e}));
  endtask
  task automatic t_single();
    mbwlh_q_t r, b;
    b = {8'h01, 8'h06, 8'h00, 8'h64, 8'h1b, 8'h58};
    xfer(b, 8, r);
    cw(b[4:5], 16'h0064);
    cq(r, host.enc(b));
    $display("single write done");
  endtask
  task automatic t_loop();
    mbwlh_q_t r, b;
    ascii_mode = 1;
    for (int k = 0; k < 2; k++)
    begin
      b = {8'h01, 8'h08, 8'h00, 8'h00, k ? 8'hff : 8'h12, k ? 8'hff : 8'h34};
      xfer(b, 17, r);
      cq(r, host.enc(b));
      chk(wq.size(), 0);
    end
    $display("loop-back done");
  endtask
  task automatic t_multi();
    mbwlh_q_t r, b;
    station_addr = 8'h02;
    host.slow = 1;
    b = {8'h02, 8'h10, 8'h00, 8'h64, 8'h00, 8'h03, 8'h06,
      8'h00, 8'hc8, 8'h00, 8'h0a, 8'h00, 8'h03};
    xfer(b, 17, r);
    cw(b[7:12], 16'h0064);
    cq(r, host.enc(b[0:5]));
    host.slow = 0;
    station_addr = 8'h01;
    ascii_mode = 0;
    $display("multi write done");
  endtask
  task automatic t_bcast();
    mbwlh_q_t r, b;
    b = {8'h00, 8'h10, 8'h00, 8'he0, 8'h00, 8'h20, 8'h40};
    for (int i = 0; i < 32; i++)
      b = {b, 8'ha5, 8'(i)};
    xfer(b, 1, r);
    cw(b[7:70], 16'h00e0);
    chk(r.size(), 0);
    b = {8'h00, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
    xfer(b, 1, r);
    cw(b[4:5], 16'h0005);
    chk(r.size(), 0);
    $display("broadcast done");
  endtask
  task automatic t_errors();
    mbwlh_q_t b;
    t_err({8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
    b = {8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h21, 8'h42};
    repeat (66) b.push_back(8'h00);
    t_err(b, 8'h03);
    t_err({8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01,
      8'h00, 8'h02}, 8'h03);
    t_err({8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, 8'h01);
    t_err({8'h01, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 8'h01);
    t_err({8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, 8'h02);
    t_err({8'h01, 8'h10, 8'h00, 8'hff, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01,
      8'h00, 8'h02}, 8'h02);
    $display("error replies done");
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1 reset = 0;
    t_single();
    t_loop();
    t_multi();
    t_bcast();
    t_errors();
    complete_run();
  end
endmodule
